// ---- logic/rtcpw_consts.svh ----
// register offsets, field positions, reset values and timing counts of the rtc power block
`ifndef RTCPW_CONSTS_SVH
`define RTCPW_CONSTS_SVH

// register byte offsets
`define RTCPW_OFF_INTCTL  16'h1900
`define RTCPW_OFF_FLAG    16'h1904
`define RTCPW_OFF_TIME    16'h1908
`define RTCPW_OFF_DATE    16'h190C
`define RTCPW_OFF_ALARM   16'h1910
`define RTCPW_OFF_STATUS  16'h1914
`define RTCPW_OFF_PM      16'h1930

// power management fields
`define RTCPW_PM_W        5
`define RTCPW_PM_CLKOUT   0
`define RTCPW_PM_REGULATOR_POWERDOWN_BIT   1
`define RTCPW_PM_REFERENCE_POWERDOWN_BIT    2
`define RTCPW_PM_WAKE_PIN_DIRECTION   3
`define RTCPW_PM_WAKE_OUTPUT_LEVEL  4
`define RTCPW_PM_RESET    5'h10

// interrupt control fields
`define RTCPW_IC_W        10
`define RTCPW_IC_ALM_LSB  0
`define RTCPW_IC_PER_LSB  4
`define RTCPW_IC_WKO_ALM  8
`define RTCPW_IC_WKO_PER  9
`define RTCPW_IC_RESET    10'h000

// flag bits
`define RTCPW_FL_ALARM    0
`define RTCPW_FL_PER      1
`define RTCPW_FL_EXTW     2

// status bits
`define RTCPW_ST_PG       0
`define RTCPW_ST_OSC      1
`define RTCPW_ST_PEND     2

// calendar reset values, bcd
`define RTCPW_TIME_RESET  32'h0100_0000
`define RTCPW_DATE_RESET  32'h0000_0101
`define RTCPW_ALARM_RESET 32'h0000_0000

// timing
`define RTCPW_RTC_HZ       32768
`define RTCPW_MS_PERIOD_US 1000
`define RTCPW_MS_TICKS     ((`RTCPW_RTC_HZ * `RTCPW_MS_PERIOD_US) / 1000000)
`define RTCPW_WR_SYNC_TICKS 2

`endif

// ---- logic/rtcpw_pkg.sv ----
// types shared by the rtc power block
package rtcpw_pkg;

  // decoded register selector
  typedef enum logic [2:0] {
    REG_NONE,
    REG_INTCTL,
    REG_FLAG,
    REG_TIME,
    REG_DATE,
    REG_ALARM,
    REG_STATUS,
    REG_PM
  } rtcpw_reg_t;

  // alarm granularity
  typedef enum logic [2:0] {
    ALM_OFF,
    ALM_SEC,
    ALM_MIN,
    ALM_HOUR,
    ALM_DAY,
    ALM_WEEK
  } rtcpw_alarm_t;

  // periodic interrupt rate
  typedef enum logic [2:0] {
    PER_OFF,
    PER_MS,
    PER_SEC,
    PER_MIN,
    PER_HOUR,
    PER_DAY
  } rtcpw_per_t;

endpackage

// ---- logic/rtcpw_top.sv ----
// rtc calendar core with power management, wake pin and wishbone register slave
// Functional notes
// (R1) writes synchronised to rtc clock, fast bus
// (R2) write visible two rtc clocks later
// (R3) oscillator stopped: all writes ignored
// (R4) power off: keep registers, drop update
// (R5) core cleared only by own power-on reset
// (R6) device reset leaves rtc core alone
// (R7) alarm, periodic, external wake wake device
// (R8) alarm or periodic can drive wake pin
// (R9) bcd calendar with leap years to 2099
// (R10) bcd values, 24-hour clock
// (R11) alarm at second to week granularity
// (R12) periodic ms, second, minute, hour, day
// (R13) all sources merge into one interrupt
// (R14) external wake pulse lasts one rtc period
// (R15) power-down bit stops regulator, power-good low
// (R16) power-good returns with supply, resets system
// (R17) bit 4 sets wake output level
// (R18) bit 3 selects wake pin direction
// (R19) input active high, output open-drain low
// (R20) software keeps pin input for wakeups
// (R21) bit 2 also stops the reference
// (R22) wake pin or alarm restores regulators
// (R23) bit 1 stops regulators, keeps reference
// (R24) bit 0 enables rtc clock output
// (R25) bits 15 to 5 read zero
// (R26) wake input sampled on rtc clock
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ns
`include "rtcpw_consts.svh"
`default_nettype none

module rtcpw_top #(
  parameter int AW        = 16,      // wishbone byte address width
  parameter int SEC_TICKS = 32768    // rtc clocks per second
) (
  // system
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          por_i,
  // wishbone slave
  input  wire logic          cyc_i,
  input  wire logic          stb_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] adr_i,
  input  wire logic [3:0]    sel_i,
  input  wire logic [31:0]   dat_i,
  output logic      [31:0]   dat_o,
  output logic               ack_o,
  // rtc oscillator
  input  wire logic          rtc_clk_i,
  input  wire logic          osc_on_i,
  output logic               rtc_clk_o,
  // power control
  input  wire logic          core_supply_ok_i,
  output logic               regulator_en_o,
  output logic               reference_en_o,
  output logic               internal_power_good_o,
  output logic               isolate_o,
  output logic               sys_reset_o,
  // wake pin, open drain
  input  wire logic          wake_pin_i,
  output logic               wake_pin_o,
  output logic               wake_pin_oe_o,
  // processor side
  output logic               irq_o,
  output logic               wake_req_o
);

  // ---------------- helpers ----------------

  // address to register selector, used by read and by write apply
  function automatic rtcpw_pkg::rtcpw_reg_t reg_decode(input logic [AW-1:0] a);
    logic [15:0] a16;
    a16 = 16'(a);
    case (a16)
      `RTCPW_OFF_INTCTL: reg_decode = rtcpw_pkg::REG_INTCTL;
      `RTCPW_OFF_FLAG:   reg_decode = rtcpw_pkg::REG_FLAG;
      `RTCPW_OFF_TIME:   reg_decode = rtcpw_pkg::REG_TIME;
      `RTCPW_OFF_DATE:   reg_decode = rtcpw_pkg::REG_DATE;
      `RTCPW_OFF_ALARM:  reg_decode = rtcpw_pkg::REG_ALARM;
      `RTCPW_OFF_STATUS: reg_decode = rtcpw_pkg::REG_STATUS;
      `RTCPW_OFF_PM:     reg_decode = rtcpw_pkg::REG_PM;
      default:           reg_decode = rtcpw_pkg::REG_NONE;
    endcase
  endfunction

  // byte-lane merge of write data into old value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] sel);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        merge[8*i +: 8] = wd[8*i +: 8];
      end
    end
  endfunction

  // bcd increment of a two-digit value
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // leap year for 2000..2099, bcd year; 2000 counts as leap
  function automatic logic bcd_leap(input logic [7:0] y);
    if (y[4] == 1'b0) begin
      bcd_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    end else begin
      bcd_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end
  endfunction

  // last day of month, bcd
  function automatic logic [7:0] month_last(input logic [7:0] m, input logic [7:0] y);
    case (m)
      8'h02:                      month_last = bcd_leap(y) ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: month_last = 8'h30;
      default:                    month_last = 8'h31;
    endcase
  endfunction

  localparam logic [15:0] SEC_LAST = 16'(SEC_TICKS - 1);           // prescaler wrap
  localparam logic [5:0]  MS_LAST  = 6'(`RTCPW_MS_TICKS - 1);      // ms counter wrap
  localparam logic [1:0]  WR_LAST  = 2'(`RTCPW_WR_SYNC_TICKS - 1); // sync age at apply

  // ---------------- declarations ----------------

  // rtc core domain, power-on reset only
  logic                  rtc_prev_r;            // last sampled rtc clock level
  logic [15:0]           presc_r;               // rtc clocks within second
  logic [5:0]            ms_cnt_r;              // rtc clocks within ms
  logic [7:0]            sec_r, min_r, hour_r;  // bcd time
  logic [7:0]            wday_r;                // weekday 1..7
  logic [7:0]            day_r, mon_r, year_r;  // bcd date
  logic [31:0]           alarm_r;               // {wday,hour,min,sec}
  logic [`RTCPW_IC_W-1:0] intctl_r;             // alarm and periodic setup
  logic [2:0]            flag_r;                // sticky event flags
  logic [`RTCPW_PM_W-1:0] pm_r;                 // power management bits
  logic                  pg_r;                  // internal power good
  logic                  sysrst_r;              // system reset pulse
  logic                  clkout_r;              // gated rtc clock out

  // bus domain, device reset
  logic                  ack_r;                 // one-cycle acknowledge
  logic [31:0]           dat_r;                 // read data
  logic                  pend_r;                // write awaiting rtc sync
  logic [AW-1:0]         pend_adr_r;
  logic [31:0]           pend_dat_r;
  logic [3:0]            pend_sel_r;
  logic [1:0]            age_r;                 // rtc clocks seen since write

  // combinational
  logic                  tick;                  // rtc clock rising edge
  logic                  sec_tick, min_car, hour_car, day_car, mon_car;
  logic [7:0]            sec_nxt, min_nxt, hour_nxt, wday_nxt, day_nxt, mon_nxt, year_nxt;
  logic                  ms_evt, alarm_evt, per_evt, ext_evt;
  logic                  wr_go;                 // pending write lands this cycle
  rtcpw_pkg::rtcpw_reg_t wr_reg;                // target of landing write
  logic                  take;                  // bus request accepted
  logic [31:0]           rd_mux;
  logic                  pg_nxt;

  // ---------------- rtc clock sampling ----------------

  // (R26) rtc edge detect
  assign tick = rtc_clk_i & ~rtc_prev_r;

  // rtc clock is slow against clk_i, so one sample per edge is enough
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      // held high so a clock already high at release is not a false edge
      rtc_prev_r <= 1'b1;
    end else begin
      rtc_prev_r <= rtc_clk_i;
    end
  end

  // (R24) clock output gate
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      clkout_r <= 1'b0;
    end else begin
      clkout_r <= rtc_clk_i & pm_r[`RTCPW_PM_CLKOUT];
    end
  end

  // ---------------- prescalers ----------------

  // second and millisecond dividers; ms runs free, not locked to the second
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      presc_r  <= 16'h0000;
      ms_cnt_r <= 6'h00;
    end else if (tick) begin
      presc_r  <= (presc_r == SEC_LAST) ? 16'h0000 : presc_r + 16'h0001;
      ms_cnt_r <= (ms_cnt_r == MS_LAST) ? 6'h00 : ms_cnt_r + 6'h01;
    end
  end

  assign sec_tick = tick && (presc_r == SEC_LAST);
  assign ms_evt   = tick && (ms_cnt_r == MS_LAST);

  // ---------------- calendar ----------------

  // (R9) carry chain through bcd fields
  always_comb begin
    sec_nxt  = sec_r;
    min_nxt  = min_r;
    hour_nxt = hour_r;
    wday_nxt = wday_r;
    day_nxt  = day_r;
    mon_nxt  = mon_r;
    year_nxt = year_r;
    min_car  = 1'b0;
    hour_car = 1'b0;
    day_car  = 1'b0;
    mon_car  = 1'b0;
    if (sec_tick) begin
      if (sec_r == 8'h59) begin
        sec_nxt = 8'h00;
        min_car = 1'b1;
      end else begin
        sec_nxt = bcd_inc(sec_r);
      end
    end
    if (min_car) begin
      if (min_r == 8'h59) begin
        min_nxt  = 8'h00;
        hour_car = 1'b1;
      end else begin
        min_nxt = bcd_inc(min_r);
      end
    end
    // (R10) 24-hour wrap
    if (hour_car) begin
      if (hour_r == 8'h23) begin
        hour_nxt = 8'h00;
        day_car  = 1'b1;
      end else begin
        hour_nxt = bcd_inc(hour_r);
      end
    end
    if (day_car) begin
      wday_nxt = (wday_r == 8'h07) ? 8'h01 : wday_r + 8'h01;
      // (R9) leap-aware month end
      if (day_r == month_last(mon_r, year_r)) begin
        day_nxt = 8'h01;
        mon_car = 1'b1;
      end else begin
        day_nxt = bcd_inc(day_r);
      end
    end
    // year 99 wraps to 00, closing the 2000..2099 span
    if (mon_car) begin
      if (mon_r == 8'h12) begin
        mon_nxt  = 8'h01;
        year_nxt = (year_r == 8'h99) ? 8'h00 : bcd_inc(year_r);
      end else begin
        mon_nxt = bcd_inc(mon_r);
      end
    end
  end

  // ---------------- events ----------------

  // (R11) alarm compare on the new time
  always_comb begin
    logic s_m, m_m, h_m, w_m;
    s_m = (sec_nxt == alarm_r[7:0]);
    m_m = (min_nxt == alarm_r[15:8]);
    h_m = (hour_nxt == alarm_r[23:16]);
    w_m = (wday_nxt == alarm_r[31:24]);
    alarm_evt = 1'b0;
    if (sec_tick) begin
      case (rtcpw_pkg::rtcpw_alarm_t'(intctl_r[`RTCPW_IC_ALM_LSB +: 3]))
        rtcpw_pkg::ALM_SEC:  alarm_evt = 1'b1;
        rtcpw_pkg::ALM_MIN:  alarm_evt = s_m;
        rtcpw_pkg::ALM_HOUR: alarm_evt = s_m & m_m;
        rtcpw_pkg::ALM_DAY:  alarm_evt = s_m & m_m & h_m;
        rtcpw_pkg::ALM_WEEK: alarm_evt = s_m & m_m & h_m & w_m;
        default:             alarm_evt = 1'b0;   // off and unused codes
      endcase
    end
  end

  // (R12) periodic rate select
  always_comb begin
    case (rtcpw_pkg::rtcpw_per_t'(intctl_r[`RTCPW_IC_PER_LSB +: 3]))
      rtcpw_pkg::PER_MS:   per_evt = ms_evt;
      rtcpw_pkg::PER_SEC:  per_evt = sec_tick;
      rtcpw_pkg::PER_MIN:  per_evt = min_car;
      rtcpw_pkg::PER_HOUR: per_evt = hour_car;
      rtcpw_pkg::PER_DAY:  per_evt = day_car;
      default:             per_evt = 1'b0;
    endcase
  end

  // (R19) input mode, active high, (R26) sampled per rtc clock
  assign ext_evt = tick && !pm_r[`RTCPW_PM_WAKE_PIN_DIRECTION] && wake_pin_i;

  // ---------------- register write sync ----------------

  // (R2) lands on the second rtc edge after the bus write
  assign wr_go  = pend_r && tick && (age_r == WR_LAST);
  assign wr_reg = reg_decode(pend_adr_r);

  // time registers; landing write beats the count of the same cycle
  always_ff @(posedge clk_i) begin
    logic [31:0] tw, dw;
    tw = merge({wday_r, hour_r, min_r, sec_r}, pend_dat_r, pend_sel_r);
    dw = merge({8'h00, year_r, mon_r, day_r}, pend_dat_r, pend_sel_r);
    // (R5) only the core power-on reset, (R6) rst_i not used here
    if (por_i) begin
      {wday_r, hour_r, min_r, sec_r} <= `RTCPW_TIME_RESET;
      {year_r, mon_r, day_r}         <= 24'(`RTCPW_DATE_RESET);
    end else if (wr_go && wr_reg == rtcpw_pkg::REG_TIME) begin
      {wday_r, hour_r, min_r, sec_r} <= tw;
    end else if (wr_go && wr_reg == rtcpw_pkg::REG_DATE) begin
      {year_r, mon_r, day_r} <= dw[23:0];
    end else begin
      // (R4) keeps running while the chip is off
      {wday_r, hour_r, min_r, sec_r} <= {wday_nxt, hour_nxt, min_nxt, sec_nxt};
      {year_r, mon_r, day_r}         <= {year_nxt, mon_nxt, day_nxt};
    end
  end

  // alarm and interrupt setup
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      alarm_r  <= `RTCPW_ALARM_RESET;
      intctl_r <= `RTCPW_IC_RESET;
    end else if (wr_go && wr_reg == rtcpw_pkg::REG_ALARM) begin
      alarm_r <= merge(alarm_r, pend_dat_r, pend_sel_r);
    end else if (wr_go && wr_reg == rtcpw_pkg::REG_INTCTL) begin
      intctl_r <= `RTCPW_IC_W'(merge(32'(intctl_r), pend_dat_r, pend_sel_r));
    end
  end

  // sticky flags, write one to clear, a new event wins over the clear
  always_ff @(posedge clk_i) begin
    logic [2:0] clr;
    clr = (wr_go && wr_reg == rtcpw_pkg::REG_FLAG) ?
          3'(merge(32'h0000_0000, pend_dat_r, pend_sel_r)) : 3'h0;
    if (por_i) begin
      flag_r <= 3'h0;
    end else begin
      // (R7) wake sources latched
      flag_r <= (flag_r & ~clr) | {ext_evt, per_evt, alarm_evt};
    end
  end

  // power management register
  always_ff @(posedge clk_i) begin
    logic [31:0] pw;
    pw = merge(32'(pm_r), pend_dat_r, pend_sel_r);
    if (por_i) begin
      // (R17) (R18) levels out of reset
      pm_r <= `RTCPW_PM_RESET;
    end else begin
      if (wr_go && wr_reg == rtcpw_pkg::REG_PM) begin
        // (R25) upper bits dropped
        pm_r <= pw[`RTCPW_PM_W-1:0];
      end
      // (R22) wake pin or alarm restores regulators and reference
      if (ext_evt || alarm_evt) begin
        pm_r[`RTCPW_PM_REGULATOR_POWERDOWN_BIT] <= 1'b0;
        pm_r[`RTCPW_PM_REFERENCE_POWERDOWN_BIT]  <= 1'b0;
      end
    end
  end

  // ---------------- power good ----------------

  // (R15) any power-down bit drops power good
  assign pg_nxt = !(pm_r[`RTCPW_PM_REGULATOR_POWERDOWN_BIT] || pm_r[`RTCPW_PM_REFERENCE_POWERDOWN_BIT]) && core_supply_ok_i;

  // (R16) power good waits for supply threshold, then one reset pulse
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      pg_r     <= 1'b0;
      sysrst_r <= 1'b0;
    end else begin
      pg_r     <= pg_nxt;
      sysrst_r <= pg_nxt & ~pg_r;
    end
  end

  // (R23) regulators off for either bit
  assign regulator_en_o        = ~(pm_r[`RTCPW_PM_REGULATOR_POWERDOWN_BIT] | pm_r[`RTCPW_PM_REFERENCE_POWERDOWN_BIT]);
  // (R21) reference off only for bit 2
  assign reference_en_o        = ~pm_r[`RTCPW_PM_REFERENCE_POWERDOWN_BIT];
  assign internal_power_good_o = pg_r;
  assign isolate_o             = ~pg_r;
  assign sys_reset_o           = sysrst_r;
  assign rtc_clk_o             = clkout_r;

  // ---------------- wake pin and interrupt ----------------

  // (R18) (R19) open drain, low only in output mode; (R17) level bit
  // (R8) alarm or periodic flag may also pull the pin
  assign wake_pin_oe_o = pm_r[`RTCPW_PM_WAKE_PIN_DIRECTION] &
                         (~pm_r[`RTCPW_PM_WAKE_OUTPUT_LEVEL] |
                          (intctl_r[`RTCPW_IC_WKO_ALM] & flag_r[`RTCPW_FL_ALARM]) |
                          (intctl_r[`RTCPW_IC_WKO_PER] & flag_r[`RTCPW_FL_PER]));
  assign wake_pin_o    = 1'b0;

  // (R13) one request for all rtc sources
  assign irq_o      = |flag_r;
  // (R7) wake from idle
  assign wake_req_o = |flag_r;

  // ---------------- wishbone slave ----------------

  // reads see live core state; isolated core reads as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (pg_r) begin
      case (reg_decode(adr_i))
        rtcpw_pkg::REG_INTCTL: rd_mux = 32'(intctl_r);
        rtcpw_pkg::REG_FLAG:   rd_mux = 32'(flag_r);
        rtcpw_pkg::REG_TIME:   rd_mux = {wday_r, hour_r, min_r, sec_r};
        rtcpw_pkg::REG_DATE:   rd_mux = {8'h00, year_r, mon_r, day_r};
        rtcpw_pkg::REG_ALARM:  rd_mux = alarm_r;
        rtcpw_pkg::REG_STATUS: rd_mux = {29'h0000_0000, pend_r, osc_on_i, pg_r};
        // (R25) reserved bits zero
        rtcpw_pkg::REG_PM:     rd_mux = 32'(pm_r);
        default:               rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // (R1) one write in flight; next write stalls until it lands
  assign take = cyc_i && stb_i && !ack_r && !(we_i && pend_r);

  // acknowledge and read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= take;
      if (take && !we_i) begin
        dat_r <= rd_mux;
      end
    end
  end

  // pending write capture and rtc-edge age
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_r     <= 1'b0;
      pend_adr_r <= '0;
      pend_dat_r <= 32'h0000_0000;
      pend_sel_r <= 4'h0;
      age_r      <= 2'h0;
    end else if (!osc_on_i || !pg_r) begin
      // (R3) stopped oscillator, (R4) update lost on power off
      pend_r <= 1'b0;
      age_r  <= 2'h0;
    end else if (take && we_i) begin
      // (R1) captured for the rtc side
      pend_r     <= 1'b1;
      pend_adr_r <= adr_i;
      pend_dat_r <= dat_i;
      pend_sel_r <= sel_i;
      age_r      <= 2'h0;
    end else if (wr_go) begin
      pend_r <= 1'b0;
      age_r  <= 2'h0;
    end else if (pend_r && tick) begin
      age_r <= age_r + 2'h1;
    end
  end

  assign ack_o = ack_r;
  assign dat_o = dat_r;

endmodule // rtcpw_top

`default_nettype wire

// ---- verification/rtcpw_props.sv ----
// port checker for the rtc power block
`timescale 1ns/1ns
`default_nettype none
module rtcpw_props (
  // system and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic por_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic ack_o,
  // clocks and power
  input wire logic rtc_clk_i,
  input wire logic rtc_clk_o,
  input wire logic core_supply_ok_i,
  input wire logic regulator_en_o,
  input wire logic reference_en_o,
  input wire logic internal_power_good_o,
  input wire logic isolate_o,
  input wire logic sys_reset_o,
  // wake pin and requests
  input wire logic wake_pin_o,
  input wire logic wake_pin_oe_o,
  input wire logic irq_o,
  input wire logic wake_req_o
);
  // either reset voids the relations
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || por_i);
  property p_ack_pulse; ack_o |=> !ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
  property p_rd_ack; cyc_i && stb_i && !we_i && !ack_o |=> ack_o; endproperty
  a_rd_ack: assert property (p_rd_ack) else $error("read not answered");
  property p_pg_reg; !regulator_en_o |=> !internal_power_good_o; endproperty
  a_pg_reg: assert property (p_pg_reg) else $error("power good with regulator off");
  property p_pg_sup; !core_supply_ok_i |=> !internal_power_good_o; endproperty
  a_pg_sup: assert property (p_pg_sup) else $error("power good without supply");
  property p_iso; isolate_o != internal_power_good_o; endproperty
  a_iso: assert property (p_iso) else $error("isolation not inverse of power good");
  property p_sysrst; $rose(internal_power_good_o) |-> sys_reset_o ##1 !sys_reset_o; endproperty
  a_sysrst: assert property (p_sysrst) else $error("system reset pulse wrong");
  property p_ref; !reference_en_o |-> !regulator_en_o; endproperty
  a_ref: assert property (p_ref) else $error("reference off, regulator on");
  property p_od; wake_pin_oe_o |-> !wake_pin_o; endproperty
  a_od: assert property (p_od) else $error("wake pin driven high");
  property p_irq; irq_o == wake_req_o; endproperty
  a_irq: assert property (p_irq) else $error("irq and wake request differ");
  property p_clkout; rtc_clk_o |-> $past(rtc_clk_i); endproperty
  a_clkout: assert property (p_clkout) else $error("clock out not from rtc clock");
endmodule // rtcpw_props
bind rtcpw_top rtcpw_props rtcpw_props_i (.clk_i, .rst_i, .por_i, .cyc_i, .stb_i, .we_i,
  .ack_o, .rtc_clk_i, .rtc_clk_o, .core_supply_ok_i, .regulator_en_o, .reference_en_o,
  .internal_power_good_o, .isolate_o, .sys_reset_o, .wake_pin_o, .wake_pin_oe_o,
  .irq_o, .wake_req_o);
`default_nettype wire

// ---- verification/rtcpw_ext_pm.sv ----
// external power manager on the wake pin and core supply
`timescale 1ns/1ns
`default_nettype none
module rtcpw_ext_pm #(
  parameter int RP   = 8,  // rtc period in clk cycles
  parameter int RAMP = 10  // supply ramp in clk cycles
) (
  // bench side
  input wire logic clk_i,
  input wire logic go_i,
  // block side
  input wire logic oe_i,
  input wire logic reg_en_i,
  output logic     wake_o,
  output logic     supply_ok_o
);
  int pc = 0; // pulse cycles left
  int sc = 0; // ramp progress
  // pulse lasts over one rtc period
  always_ff @(posedge clk_i) begin
    if (go_i) pc <= RP + 2;
    else if (pc > 0) pc <= pc - 1;
  end
  // open drain low beats our level, idle low
  assign wake_o = oe_i ? 1'b0 : (pc > 0);
  // supply drops at once, returns slowly
  always_ff @(posedge clk_i) begin
    if (reg_en_i !== 1'b1) sc <= 0;
    else if (sc < RAMP) sc <= sc + 1;
  end
  assign supply_ok_o = (reg_en_i === 1'b1) && (sc >= RAMP);
endmodule // rtcpw_ext_pm
`default_nettype wire

// ---- verification/rtcpw_top_tb.sv ----
// self-checking bench for the rtc power block
`timescale 1ns/1ns
`include "rtcpw_consts.svh"
`default_nettype none
module rtcpw_top_tb;
  localparam int RP = 8; // rtc period in clk cycles
  // bus side stimulus
  logic clk_i = 0, rst_i = 1, por_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic osc_on_i = 1, go = 0;
  logic [15:0] adr_i = 0;
  logic [31:0] dat_i = 0;
  logic [3:0] sel_i = 4'hf;
  logic [2:0] rc = 0;
  // block outputs, plus the rtc clock, supply and wake pin inputs
  logic [31:0] dat_o;
  logic ack_o, rtc_clk_i, rtc_clk_o, core_supply_ok_i, regulator_en_o, reference_en_o;
  logic internal_power_good_o, isolate_o, sys_reset_o, wake_pin_i, wake_pin_o;
  logic wake_pin_oe_o, irq_o, wake_req_o;
  logic [31:0] q[$]; // expected read data, oldest first
  int errors = 0, checks_done = 0, seed = 913;
  // interrupt setups and the flags each one leaves behind
  logic [31:0] iv[3] = '{32'h310, 32'h020, 32'h101};
  logic [31:0] fv[3] = '{32'h2, 32'h2, 32'h1};
  rtcpw_top #(.SEC_TICKS(8)) rtcpw_top_i (.clk_i, .rst_i, .por_i, .cyc_i, .stb_i, .we_i,
    .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .rtc_clk_i, .osc_on_i, .rtc_clk_o,
    .core_supply_ok_i, .regulator_en_o, .reference_en_o, .internal_power_good_o,
    .isolate_o, .sys_reset_o, .wake_pin_i, .wake_pin_o, .wake_pin_oe_o, .irq_o, .wake_req_o);
  rtcpw_ext_pm #(.RP(RP)) rtcpw_ext_pm_i (.clk_i, .go_i(go), .oe_i(wake_pin_oe_o),
    .reg_en_i(regulator_en_o), .wake_o(wake_pin_i), .supply_ok_o(core_supply_ok_i));
  initial forever #20 clk_i = ~clk_i;
  // slow rtc clock, far under a third of clk
  always @(posedge clk_i) rc <= rc + 3'h1;
  assign rtc_clk_i = rc[2];
  task automatic give_verdict;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  // monitor pairs each read answer with oldest note
  always @(posedge clk_i) if (ack_o === 1'b1 && we_i === 1'b0) cmp(dat_o, q.pop_front());
  // bounded wait: k=0 irq high, else power good high
  task automatic wt(input int k);
    int n;
    n = 0;
    do begin @(posedge clk_i); n++; end
    while ((k == 0 ? irq_o : internal_power_good_o) !== 1'b1 && n < 4000);
    if (n >= 4000) begin errors++; $display("BAD %0t wait expired", $time); give_verdict(); end
  endtask
  // classic cycle, held until ack, then a gap cycle
  task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= a; dat_i <= d;
    n = 0;
    do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 4000);
    if (n >= 4000) begin errors++; $display("BAD %0t no ack", $time); give_verdict(); end
    cyc_i <= 0; stb_i <= 0; we_i <= 0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    q.push_back(e);
    wb(0, a, 32'h0);
  endtask
  task automatic ticks(input int n);
    repeat (n * RP) @(posedge clk_i);
  endtask
  initial begin
    logic [31:0] r;
    repeat (16) @(posedge clk_i);
    rst_i <= 0; por_i <= 0;
    repeat (3) @(posedge clk_i);
    rd(`RTCPW_OFF_PM, 32'h10);
    r = $random(seed) & 32'hffff_fff9;
    wb(1, `RTCPW_OFF_PM, r);
    rd(`RTCPW_OFF_PM, 32'h10);
    ticks(3);
    rd(`RTCPW_OFF_PM, r & 32'h1f);
    cmp(32'(wake_pin_oe_o), 32'(r[3] & ~r[4]));
    rst_i <= 1; @(posedge clk_i); rst_i <= 0; @(posedge clk_i);
    rd(`RTCPW_OFF_PM, r & 32'h1f);
    osc_on_i <= 0; wb(1, `RTCPW_OFF_PM, ~r & 32'h19); ticks(3);
    rd(`RTCPW_OFF_PM, r & 32'h1f);
    osc_on_i <= 1;
    for (int i = 0; i < 2; i++) begin
      wb(1, `RTCPW_OFF_PM, 32'h08 | (i << 4)); ticks(3);
      cmp(32'(wake_pin_oe_o), 32'(i == 0));
    end
    for (int k = 0; k < 3; k++) begin
      wb(1, `RTCPW_OFF_INTCTL, iv[k]); wt(0);
      @(posedge clk_i);
      cmp(32'(wake_pin_oe_o), 32'(k != 1));
      wb(1, `RTCPW_OFF_INTCTL, 32'h0); ticks(3);
      rd(`RTCPW_OFF_FLAG, fv[k]);
      wb(1, `RTCPW_OFF_FLAG, 32'h7); ticks(3);
      cmp(32'(irq_o), 32'h0);
    end
    for (int b = 1; b < 3; b++) begin
      wb(1, `RTCPW_OFF_PM, 32'h10 | (1 << b)); ticks(3);
      cmp(32'(regulator_en_o), 32'h0);
      cmp(32'(reference_en_o), 32'(b == 1));
      cmp(32'(internal_power_good_o), 32'h0);
      rd(`RTCPW_OFF_PM, 32'h0);
      go <= 1; @(posedge clk_i); go <= 0;
      wt(1);
      rd(`RTCPW_OFF_PM, 32'h10);
      rd(`RTCPW_OFF_FLAG, 32'h4);
      wb(1, `RTCPW_OFF_FLAG, 32'h7); ticks(3);
    end
    // weekly alarm on midnight rollover into a leap day
    wb(1, `RTCPW_OFF_ALARM, 32'h0100_0000);
    wb(1, `RTCPW_OFF_INTCTL, 32'h0000_0005);
    wb(1, `RTCPW_OFF_DATE, 32'h0024_0228);
    wb(1, `RTCPW_OFF_TIME, 32'h0723_5959);
    wt(0);
    rd(`RTCPW_OFF_TIME, 32'h0100_0000);
    rd(`RTCPW_OFF_DATE, 32'h0024_0229);
    rd(`RTCPW_OFF_FLAG, 32'h0000_0001);
    give_verdict();
  end
endmodule // rtcpw_top_tb
`default_nettype wire
